//--- shared/rtxm_pkg.sv
// rtxm_pkg: offsets, field positions, reset values and codes of the
// communication page settings; assumes 6-bit register addresses.
package rtxm_pkg;
  localparam logic [5:0] ADDR_RSVD  = 6'h10;
  localparam logic [5:0] ADDR_GEN   = 6'h11;
  localparam logic [5:0] ADDR_TX    = 6'h12;
  localparam logic [7:0] RST_RSVD   = 8'h00;
  localparam logic [7:0] RST_GEN    = 8'h3f;
  localparam logic [7:0] RST_TX     = 8'h00;
  localparam logic [7:0] RD_NONE    = 8'h00;
  localparam logic [7:0] GEN_WMASK  = 8'hab;
  localparam int         GEN_MSB    = 7;
  localparam int         GEN_WAITRF = 5;
  localparam int         GEN_POL    = 3;
  localparam int         GEN_SEED_H = 1;
  localparam int         GEN_SEED_L = 0;
  localparam int         TX_CRC     = 7;
  localparam int         TX_RATE_H  = 6;
  localparam int         TX_RATE_L  = 4;
  localparam int         TX_INV     = 3;
  localparam int         TX_FRM_H   = 1;
  localparam int         TX_FRM_L   = 0;
  localparam logic [2:0] RATE_106   = 3'h0;
  localparam logic [2:0] RATE_MAX   = 3'h3;
  localparam logic [1:0] FRM_A      = 2'h0;
  localparam logic [1:0] FRM_B      = 2'h3;
  localparam logic [1:0] SEL_6363   = 2'h1;
  localparam logic [1:0] SEL_A671   = 2'h2;
  localparam logic [1:0] SEL_FFFF   = 2'h3;
  localparam logic [15:0] SEED_0000 = 16'h0000;
  localparam logic [15:0] SEED_6363 = 16'h6363;
  localparam logic [15:0] SEED_A671 = 16'ha671;
  localparam logic [15:0] SEED_FFFF = 16'hffff;
  localparam logic       ENV_IDLE   = 1'b1;
  typedef enum logic [2:0] {
    TXS_IDLE  = 3'b001,
    TXS_FIELD = 3'b010,
    TXS_RUN   = 3'b100
  } rtxm_tx_state_t;
endpackage

//--- shared/rtxm_cfg_if.sv
// rtxm_cfg_if: settings fanned out from the register bank
// assumes one driver, the register bank, on the src side.
interface rtxm_cfg_if;
  logic       crc_high_bit_leading;
  logic [1:0] crc_seed_sel;
  logic [1:0] tx_framing_sel;
  logic       ext_envelope_polarity;
  modport src (output crc_high_bit_leading, output crc_seed_sel,
               output tx_framing_sel, output ext_envelope_polarity);
  modport crc (input crc_high_bit_leading, input crc_seed_sel,
               input tx_framing_sel);
  modport env (input ext_envelope_polarity);
endinterface

//--- hw/rtxm_crc_view.sv
// rtxm_crc_view: crc bit order, start value and result presentation
// assumes the crc engine result is stable when it is sampled.
module rtxm_crc_view (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  rtxm_cfg_if.crc          cfg,
  input  wire logic        rf_comm_active,
  input  wire logic        rf_tx_phase,
  input  wire logic [1:0]  rx_framing_sel,
  input  wire logic [15:0] crc_result_raw,
  output logic             crc_high_bit_leading,
  output logic [15:0]      crc_seed,
  output logic [7:0]       crc_result_upper,
  output logic [7:0]       crc_result_lower
);
  logic        msb_eff;
  logic [1:0]  frm;
  logic [15:0] rev;
  logic [15:0] seed_next;

  // protocol order wins while the link is busy
  assign msb_eff = cfg.crc_high_bit_leading && !rf_comm_active; // R1 R3
  assign frm     = rf_tx_phase ? cfg.tx_framing_sel : rx_framing_sel;

  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_rev
      assign rev[8+i] = crc_result_raw[15-i]; // R2
      assign rev[i]   = crc_result_raw[7-i]; // R2
    end
  endgenerate

  always_comb
  begin
    if (rf_comm_active)
      seed_next = (frm == rtxm_pkg::FRM_B) ? rtxm_pkg::SEED_FFFF : rtxm_pkg::SEED_6363; // R9
    else
      case (cfg.crc_seed_sel) // R8
        rtxm_pkg::SEL_6363: seed_next = rtxm_pkg::SEED_6363;
        rtxm_pkg::SEL_A671: seed_next = rtxm_pkg::SEED_A671;
        rtxm_pkg::SEL_FFFF: seed_next = rtxm_pkg::SEED_FFFF;
        default:            seed_next = rtxm_pkg::SEED_0000;
      endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      crc_high_bit_leading <= 1'b0;
      crc_seed             <= rtxm_pkg::SEED_FFFF;
      crc_result_upper     <= rtxm_pkg::RD_NONE;
      crc_result_lower     <= rtxm_pkg::RD_NONE;
    end
    else
    begin
      crc_high_bit_leading <= msb_eff; // R1
      crc_seed             <= seed_next;
      crc_result_upper     <= msb_eff ? rev[15:8] : crc_result_raw[15:8]; // R2
      crc_result_lower     <= msb_eff ? rev[7:0] : crc_result_raw[7:0]; // R2
    end
  end
endmodule

//--- hw/rtxm_env_pol.sv
// rtxm_env_pol: external envelope input polarity and change event
// assumes the envelope pin is already synchronous to sys_clk.
module rtxm_env_pol (
  input  wire logic sys_clk,
  input  wire logic srst,
  rtxm_cfg_if.env   cfg,
  input  wire logic ext_envelope_in,
  output logic      ext_envelope_n,
  output logic      ext_input_active_event
);
  logic pol_d_reg;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      ext_envelope_n <= rtxm_pkg::ENV_IDLE;
    else if (cfg.ext_envelope_polarity)
      ext_envelope_n <= !ext_envelope_in; // R5 R6
    else
      ext_envelope_n <= ext_envelope_in; // R5 R6
  end

  // history resets to the reset polarity so reset makes no event
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      pol_d_reg              <= rtxm_pkg::RST_GEN[rtxm_pkg::GEN_POL];
      ext_input_active_event <= 1'b0;
    end
    else
    begin
      pol_d_reg              <= cfg.ext_envelope_polarity;
      ext_input_active_event <= cfg.ext_envelope_polarity != pol_d_reg; // R7
    end
  end
endmodule

//--- hw/rtxm_regs.sv
// rtxm_regs: communication page settings bank of the contactless reader
// assumes the host interface gives one-cycle read and write strobes.

//Function
//R1 - crc bit-order bit set makes the crc engine work high bit first
//R2 - with that bit set both crc result bytes read bit reversed
//R3 - during rf communication the bit-order bit is ignored
//R4 - with field-wait bit set the transmitter starts only under an rf field
//R5 - polarity bit picks the envelope pin level: 1 high, 0 low
//R6 - internal envelope signal is always active low
//R7 - each change of the polarity bit raises the input-active event
//R8 - seed field picks crc start value 0000, 6363, a671 or ffff
//R9 - during rf communication the start value comes from framing settings
//R10 - transmit crc enable appends a crc to sent data
//R11 - transmit crc enable may be zero only at 106 kBd
//R12 - rate field 000..011 gives 106..848 kBd; higher codes reserved
//R13 - invert bit inverts transmit modulation
//R14 - framing 00 is type A, 11 type B, others reserved
//R15 - register 10h has no function and reads 00h
//R16 - general settings register resets to 3fh
//R17 - transmit settings register resets to 00h
//R18 - reserved bits ignore writes and read their reset value
module rtxm_regs (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  input  wire logic        tx_start_req,
  input  wire logic        tx_done,
  input  wire logic        rf_field_on,
  output logic             tx_run,
  input  wire logic        rf_comm_active,
  input  wire logic        rf_tx_phase,
  input  wire logic [1:0]  rx_framing_sel,
  input  wire logic [15:0] crc_result_raw,
  output logic             crc_high_bit_leading,
  output logic [15:0]      crc_seed,
  output logic [7:0]       crc_result_upper,
  output logic [7:0]       crc_result_lower,
  input  wire logic        ext_envelope_in,
  output logic             ext_envelope_n,
  output logic             ext_input_active_event,
  output logic             tx_crc_gen_on,
  output logic [2:0]       tx_bit_rate_sel,
  output logic             tx_modulation_invert,
  output logic [1:0]       tx_framing_sel,
  input  wire logic        tx_mod_in,
  output logic             tx_mod_out
);
  logic [7:0]               gen_reg;
  logic [7:0]               gen_next;
  logic [7:0]               tx_reg;
  logic [7:0]               tx_next;
  logic [7:0]               rdata_next;
  logic                     wr_gen;
  logic                     wr_tx;
  logic [2:0]               rate_w;
  logic [1:0]               frm_w;
  logic                     rate_ok;
  logic                     frm_ok;
  rtxm_pkg::rtxm_tx_state_t state_reg;
  rtxm_pkg::rtxm_tx_state_t state_next;

  rtxm_cfg_if cfg ();

  assign cfg.crc_high_bit_leading  = gen_reg[rtxm_pkg::GEN_MSB];
  assign cfg.crc_seed_sel          = gen_reg[rtxm_pkg::GEN_SEED_H:rtxm_pkg::GEN_SEED_L];
  assign cfg.ext_envelope_polarity = gen_reg[rtxm_pkg::GEN_POL];
  assign cfg.tx_framing_sel        = tx_reg[rtxm_pkg::TX_FRM_H:rtxm_pkg::TX_FRM_L];

  // register port decode; 10h decodes to nothing writable
  assign wr_gen  = reg_wr && (reg_addr == rtxm_pkg::ADDR_GEN);
  assign wr_tx   = reg_wr && (reg_addr == rtxm_pkg::ADDR_TX);
  assign rate_w  = reg_wdata[rtxm_pkg::TX_RATE_H:rtxm_pkg::TX_RATE_L];
  assign frm_w   = reg_wdata[rtxm_pkg::TX_FRM_H:rtxm_pkg::TX_FRM_L];
  assign rate_ok = rate_w <= rtxm_pkg::RATE_MAX; // R12
  assign frm_ok  = (frm_w == rtxm_pkg::FRM_A) || (frm_w == rtxm_pkg::FRM_B); // R14

  // reserved bits are rebuilt from the reset value on every write
  always_comb
  begin
    gen_next = (reg_wdata & rtxm_pkg::GEN_WMASK) | (rtxm_pkg::RST_GEN & ~rtxm_pkg::GEN_WMASK); // R18
  end

  // reserved codes are refused so the transmitter never sees them
  always_comb
  begin
    tx_next = tx_reg;
    if (rate_ok)
      tx_next[rtxm_pkg::TX_RATE_H:rtxm_pkg::TX_RATE_L] = rate_w; // R12
    if (frm_ok)
      tx_next[rtxm_pkg::TX_FRM_H:rtxm_pkg::TX_FRM_L] = frm_w; // R14
    tx_next[rtxm_pkg::TX_INV] = reg_wdata[rtxm_pkg::TX_INV]; // R13
    tx_next[rtxm_pkg::TX_CRC] = reg_wdata[rtxm_pkg::TX_CRC]
      | (tx_next[rtxm_pkg::TX_RATE_H:rtxm_pkg::TX_RATE_L] != rtxm_pkg::RATE_106); // R10 R11
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      gen_reg <= rtxm_pkg::RST_GEN; // R16
    else if (wr_gen)
      gen_reg <= gen_next;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      tx_reg <= rtxm_pkg::RST_TX; // R17
    else if (wr_tx)
      tx_reg <= tx_next;
  end

  always_comb
  begin
    case (reg_addr)
      rtxm_pkg::ADDR_RSVD: rdata_next = rtxm_pkg::RST_RSVD; // R15
      rtxm_pkg::ADDR_GEN:  rdata_next = gen_reg;
      rtxm_pkg::ADDR_TX:   rdata_next = tx_reg;
      default:             rdata_next = rtxm_pkg::RD_NONE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      reg_rdata <= rtxm_pkg::RD_NONE;
    else if (reg_rd)
      reg_rdata <= rdata_next;
  end

  // transmit start gate; a held request waits for the field
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      rtxm_pkg::TXS_IDLE:
        if (tx_start_req)
        begin
          if (gen_reg[rtxm_pkg::GEN_WAITRF] && !rf_field_on)
            state_next = rtxm_pkg::TXS_FIELD; // R4
          else
            state_next = rtxm_pkg::TXS_RUN;
        end
      rtxm_pkg::TXS_FIELD:
        if (rf_field_on || !gen_reg[rtxm_pkg::GEN_WAITRF])
          state_next = rtxm_pkg::TXS_RUN; // R4
      rtxm_pkg::TXS_RUN:
        if (tx_done)
          state_next = rtxm_pkg::TXS_IDLE;
      default:
        state_next = rtxm_pkg::TXS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      state_reg <= rtxm_pkg::TXS_IDLE;
    else
      state_reg <= state_next;
  end

  assign tx_run = state_reg == rtxm_pkg::TXS_RUN;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      tx_mod_out <= 1'b0;
    else
      tx_mod_out <= tx_mod_in ^ tx_reg[rtxm_pkg::TX_INV]; // R13
  end

  assign tx_crc_gen_on        = tx_reg[rtxm_pkg::TX_CRC]; // R10
  assign tx_bit_rate_sel      = tx_reg[rtxm_pkg::TX_RATE_H:rtxm_pkg::TX_RATE_L];
  assign tx_modulation_invert = tx_reg[rtxm_pkg::TX_INV];
  assign tx_framing_sel       = tx_reg[rtxm_pkg::TX_FRM_H:rtxm_pkg::TX_FRM_L];

  rtxm_crc_view u_crc (
    .sys_clk              (sys_clk),
    .srst                 (srst),
    .cfg                  (cfg.crc),
    .rf_comm_active       (rf_comm_active),
    .rf_tx_phase          (rf_tx_phase),
    .rx_framing_sel       (rx_framing_sel),
    .crc_result_raw       (crc_result_raw),
    .crc_high_bit_leading (crc_high_bit_leading),
    .crc_seed             (crc_seed),
    .crc_result_upper     (crc_result_upper),
    .crc_result_lower     (crc_result_lower)
  );

  rtxm_env_pol u_env (
    .sys_clk                (sys_clk),
    .srst                   (srst),
    .cfg                    (cfg.env),
    .ext_envelope_in        (ext_envelope_in),
    .ext_envelope_n         (ext_envelope_n),
    .ext_input_active_event (ext_input_active_event)
  );

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  property p_msb_order;
    (gen_reg[rtxm_pkg::GEN_MSB] && !rf_comm_active) |=> crc_high_bit_leading;
  endproperty
  a_msb_order: assert property (p_msb_order) else $error("crc high bit order not applied"); // R1

  property p_byte_reverse;
    (gen_reg[rtxm_pkg::GEN_MSB] && !rf_comm_active) |=>
      (crc_result_upper[0] == $past(crc_result_raw[15]))
      && (crc_result_lower[7] == $past(crc_result_raw[0]));
  endproperty
  a_byte_reverse: assert property (p_byte_reverse) else $error("crc result not bit reversed"); // R2

  property p_comm_order;
    rf_comm_active |=> !crc_high_bit_leading;
  endproperty
  a_comm_order: assert property (p_comm_order) else $error("bit order not forced in communication"); // R3

  property p_field_gate;
    (state_reg == rtxm_pkg::TXS_FIELD && !rf_field_on && gen_reg[rtxm_pkg::GEN_WAITRF]) |=> !tx_run;
  endproperty
  a_field_gate: assert property (p_field_gate) else $error("transmitter started without field"); // R4

  property p_env_level;
    1'b1 |=> ext_envelope_n == ($past(gen_reg[rtxm_pkg::GEN_POL]) ^ $past(ext_envelope_in));
  endproperty
  a_env_level: assert property (p_env_level) else $error("internal envelope level wrong"); // R5 R6

  property p_pol_event;
    $changed(gen_reg[rtxm_pkg::GEN_POL]) |=> ext_input_active_event ##1 !ext_input_active_event;
  endproperty
  a_pol_event: assert property (p_pol_event) else $error("polarity change gave no single event"); // R7

  property p_seed_sel;
    (!rf_comm_active && gen_reg[rtxm_pkg::GEN_SEED_H:rtxm_pkg::GEN_SEED_L] == rtxm_pkg::SEL_A671)
      |=> crc_seed == rtxm_pkg::SEED_A671;
  endproperty
  a_seed_sel: assert property (p_seed_sel) else $error("crc seed does not follow field"); // R8

  property p_auto_seed;
    (rf_comm_active && rf_tx_phase && tx_framing_sel == rtxm_pkg::FRM_A)
      |=> crc_seed == rtxm_pkg::SEED_6363;
  endproperty
  a_auto_seed: assert property (p_auto_seed) else $error("automatic seed not used"); // R9

  property p_crc_forced;
    (tx_bit_rate_sel != rtxm_pkg::RATE_106) |-> tx_crc_gen_on;
  endproperty
  a_crc_forced: assert property (p_crc_forced) else $error("crc off above lowest rate"); // R11

  property p_crc_write;
    (wr_tx && reg_wdata[rtxm_pkg::TX_CRC]) |=> tx_crc_gen_on;
  endproperty
  a_crc_write: assert property (p_crc_write) else $error("crc enable write lost"); // R10

  property p_rate_rsvd;
    (wr_tx && !rate_ok) |=> $stable(tx_bit_rate_sel);
  endproperty
  a_rate_rsvd: assert property (p_rate_rsvd) else $error("reserved rate code taken"); // R12

  property p_frm_rsvd;
    (wr_tx && !frm_ok) |=> $stable(tx_framing_sel);
  endproperty
  a_frm_rsvd: assert property (p_frm_rsvd) else $error("reserved framing code taken"); // R14

  property p_mod_inv;
    1'b1 |=> tx_mod_out == ($past(tx_mod_in) ^ $past(tx_modulation_invert));
  endproperty
  a_mod_inv: assert property (p_mod_inv) else $error("modulation inversion wrong"); // R13

  property p_rsvd_read;
    (reg_rd && reg_addr == rtxm_pkg::ADDR_RSVD) |=> reg_rdata == rtxm_pkg::RST_RSVD;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("register 10h not zero"); // R15

  property p_reset_vals;
    disable iff (1'b0) srst |=> (gen_reg == rtxm_pkg::RST_GEN) && (tx_reg == rtxm_pkg::RST_TX);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong"); // R16 R17

  property p_rsvd_bits;
    (reg_rd && reg_addr == rtxm_pkg::ADDR_GEN) |=>
      (reg_rdata & ~rtxm_pkg::GEN_WMASK) == (rtxm_pkg::RST_GEN & ~rtxm_pkg::GEN_WMASK);
  endproperty
  a_rsvd_bits: assert property (p_rsvd_bits) else $error("reserved bits changed"); // R18

  property p_rate_take;
    (wr_tx && rate_ok) |=> tx_bit_rate_sel == $past(rate_w);
  endproperty
  a_rate_take: assert property (p_rate_take) else $error("valid rate code not stored"); // R12

  property p_frm_take;
    (wr_tx && frm_ok) |=> tx_framing_sel == $past(frm_w);
  endproperty
  a_frm_take: assert property (p_frm_take) else $error("valid framing code not stored"); // R14

  property p_crc_low_rate;
    (wr_tx && rate_w == rtxm_pkg::RATE_106 && !reg_wdata[rtxm_pkg::TX_CRC]) |=> !tx_crc_gen_on;
  endproperty
  a_crc_low_rate: assert property (p_crc_low_rate) else $error("crc enable not cleared at lowest rate"); // R11

  property p_gen_write;
    wr_gen |=> (gen_reg & rtxm_pkg::GEN_WMASK) == ($past(reg_wdata) & rtxm_pkg::GEN_WMASK);
  endproperty
  a_gen_write: assert property (p_gen_write) else $error("general settings write lost"); // R1 R4 R5 R8

  property p_rsvd_no_write;
    (reg_wr && reg_addr == rtxm_pkg::ADDR_RSVD) |=> $stable(gen_reg) && $stable(tx_reg);
  endproperty
  a_rsvd_no_write: assert property (p_rsvd_no_write) else $error("write to register 10h had an effect"); // R15

  property p_start_wait;
    (state_reg == rtxm_pkg::TXS_IDLE && tx_start_req && gen_reg[rtxm_pkg::GEN_WAITRF] && !rf_field_on)
      |=> !tx_run;
  endproperty
  a_start_wait: assert property (p_start_wait) else $error("transmitter started before the field"); // R4

  property p_auto_seed_rx;
    (rf_comm_active && !rf_tx_phase && rx_framing_sel == rtxm_pkg::FRM_B)
      |=> crc_seed == rtxm_pkg::SEED_FFFF;
  endproperty
  a_auto_seed_rx: assert property (p_auto_seed_rx) else $error("receive framing seed not used"); // R9

  property p_plain_order;
    (!gen_reg[rtxm_pkg::GEN_MSB] || rf_comm_active) |=>
      {crc_result_upper, crc_result_lower} == $past(crc_result_raw);
  endproperty
  a_plain_order: assert property (p_plain_order) else $error("crc result reversed without cause"); // R2 R3

  // guards against a false event, e.g. straight after reset
  property p_event_cause;
    ext_input_active_event |-> $past(gen_reg[rtxm_pkg::GEN_POL]) != $past(gen_reg[rtxm_pkg::GEN_POL], 2);
  endproperty
  a_event_cause: assert property (p_event_cause) else $error("input-active event without polarity change"); // R7

  c_wait_field: cover property (state_reg == rtxm_pkg::TXS_FIELD ##1 tx_run);
  c_pol_event: cover property (ext_input_active_event);
  c_msb_first: cover property (crc_high_bit_leading ##1 rf_comm_active);
  c_rsvd_rate: cover property (wr_tx && !rate_ok);
  c_auto_seed: cover property (rf_comm_active && rf_tx_phase && tx_framing_sel == rtxm_pkg::FRM_A);
endmodule

//--- testbench/rtxm_host_model.sv
// rtxm_host_model: host side of the register strobe port
// assumes one-cycle strobes taken on the rising edge of sys_clk.
module rtxm_host_model (
  input  wire logic       sys_clk,
  output logic [5:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // idle bus shows inverted values so a stale address cannot look valid
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask
endmodule

//--- testbench/rtxm_regs_tb.sv
// rtxm_regs_tb: register, crc view, envelope and transmit gate checks
// assumes the host model drives the register port of rtxm_regs.
module rtxm_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic [5:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        tx_start_req = 1'b0;
  logic        tx_done = 1'b0;
  logic        rf_field_on = 1'b0;
  logic        tx_run;
  logic        rf_comm_active = 1'b0;
  logic        rf_tx_phase = 1'b0;
  logic [1:0]  rx_framing_sel = 2'h0;
  logic [15:0] crc_result_raw = 16'h1e01;
  logic        crc_high_bit_leading;
  logic [15:0] crc_seed;
  logic [7:0]  crc_result_upper;
  logic [7:0]  crc_result_lower;
  logic        ext_envelope_in = 1'b0;
  logic        ext_envelope_n;
  logic        ext_input_active_event;
  logic        tx_crc_gen_on;
  logic [2:0]  tx_bit_rate_sel;
  logic        tx_modulation_invert;
  logic [1:0]  tx_framing_sel;
  logic        tx_mod_in = 1'b1;
  logic        tx_mod_out;
  int          errors = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          ev_cnt = 0;
  int          ev0;
  logic [7:0]  rv;
  logic [7:0]  tx_w [5] = '{8'hbb, 8'hc9, 8'h1c, 8'h00, 8'h23};
  // reserved codes keep old fields, crc off only at the lowest rate
  logic [7:0]  tx_e [5] = '{8'hbb, 8'hbb, 8'h98, 8'h00, 8'ha3};
  logic [15:0] seeds [4] = '{16'h0000, 16'h6363, 16'ha671, 16'hffff};

  rtxm_host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  rtxm_regs uut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_start_req(tx_start_req),
    .tx_done(tx_done), .rf_field_on(rf_field_on), .tx_run(tx_run), .rf_comm_active(rf_comm_active),
    .rf_tx_phase(rf_tx_phase), .rx_framing_sel(rx_framing_sel), .crc_result_raw(crc_result_raw),
    .crc_high_bit_leading(crc_high_bit_leading), .crc_seed(crc_seed),
    .crc_result_upper(crc_result_upper), .crc_result_lower(crc_result_lower),
    .ext_envelope_in(ext_envelope_in), .ext_envelope_n(ext_envelope_n),
    .ext_input_active_event(ext_input_active_event), .tx_crc_gen_on(tx_crc_gen_on),
    .tx_bit_rate_sel(tx_bit_rate_sel), .tx_modulation_invert(tx_modulation_invert),
    .tx_framing_sel(tx_framing_sel), .tx_mod_in(tx_mod_in), .tx_mod_out(tx_mod_out));

  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    if (ext_input_active_event === 1'b1)
      ev_cnt <= ev_cnt + 1;
  end
  // hang guard, far above the roughly 190 cycles the sequence needs
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      errors = errors + 1;
      finish_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // registered outputs settle within two edges after the write
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    host.rd(6'h10, rv);
    check(rv, 8'h00);
    host.rd(6'h11, rv);
    check(rv, 8'h3f);
    host.rd(6'h12, rv);
    check(rv, 8'h00);
    check({tx_crc_gen_on, tx_bit_rate_sel, tx_modulation_invert, tx_framing_sel}, 7'h00);
    check(crc_seed, 16'hffff);
    host.wr(6'h10, 8'hff);
    host.wr(6'h3f, 8'h5a);
    host.rd(6'h10, rv);
    check(rv, 8'h00);
    host.rd(6'h3f, rv);
    check(rv, 8'h00);
    for (int s = 0; s < 4; s++)
    begin
      host.wr(6'h11, 8'h08 | 8'(s));
      settle();
      check(crc_seed, seeds[s]);
      host.rd(6'h11, rv);
      check(rv, 8'h1c | 8'(s));
    end
    check(ev_cnt, 0);
    @(posedge sys_clk);
    rf_comm_active <= 1'b1;
    rf_tx_phase <= 1'b0;
    settle();
    check(crc_seed, 16'h6363);
    // auto seed follows transmit framing during the transmit phase
    host.wr(6'h12, 8'h03);
    @(posedge sys_clk);
    rf_tx_phase <= 1'b1;
    settle();
    check(crc_seed, 16'hffff);
    // receive framing alone decides in the receive phase
    host.wr(6'h12, 8'h00);
    @(posedge sys_clk);
    rf_tx_phase <= 1'b0;
    rx_framing_sel <= 2'h3;
    settle();
    check(crc_seed, 16'hffff);
    @(posedge sys_clk);
    rf_tx_phase <= 1'b1;
    settle();
    check(crc_seed, 16'h6363);
    host.wr(6'h11, 8'h80);
    settle();
    check(crc_high_bit_leading, 1'b0);
    check({crc_result_upper, crc_result_lower}, 16'h1e01);
    @(posedge sys_clk);
    rf_comm_active <= 1'b0;
    settle();
    check(crc_high_bit_leading, 1'b1);
    check({crc_result_upper, crc_result_lower}, 16'h7880);
    check(crc_seed, 16'h0000);
    check(ev_cnt, 1);
    host.rd(6'h11, rv);
    check(rv, 8'h94);
    for (int p = 0; p < 4; p++)
    begin
      @(posedge sys_clk);
      ext_envelope_in <= p[0];
      settle();
      check(ext_envelope_n, p[0]);
    end
    ev0 = ev_cnt;
    host.wr(6'h11, 8'ha8);
    settle();
    check(ev_cnt, ev0 + 1);
    host.wr(6'h11, 8'ha8);
    settle();
    check(ev_cnt, ev0 + 1);
    for (int p = 0; p < 2; p++)
    begin
      @(posedge sys_clk);
      ext_envelope_in <= p[0];
      settle();
      check(ext_envelope_n, !p[0]);
    end
    for (int i = 0; i < 5; i++)
    begin
      host.wr(6'h12, tx_w[i]);
      settle();
      host.rd(6'h12, rv);
      check(rv, tx_e[i]);
      check(tx_crc_gen_on, tx_e[i][7]);
      check(tx_bit_rate_sel, tx_e[i][6:4]);
      check(tx_modulation_invert, tx_e[i][3]);
      check(tx_framing_sel, tx_e[i][1:0]);
      check(tx_mod_out, !tx_e[i][3]);
    end
    @(posedge sys_clk);
    tx_mod_in <= 1'b0;
    settle();
    check(tx_mod_out, 1'b0);
    @(posedge sys_clk);
    tx_start_req <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    check(tx_run, 1'b0);
    @(posedge sys_clk);
    rf_field_on <= 1'b1;
    settle();
    check(tx_run, 1'b1);
    @(posedge sys_clk);
    tx_start_req <= 1'b0;
    rf_field_on <= 1'b0;
    tx_done <= 1'b1;
    @(posedge sys_clk);
    tx_done <= 1'b0;
    settle();
    check(tx_run, 1'b0);
    host.wr(6'h11, 8'h88);
    settle();
    @(posedge sys_clk);
    tx_start_req <= 1'b1;
    settle();
    check(tx_run, 1'b1);
    finish_test();
  end
endmodule
